//--- rtl/rcpc_regs.sv
// The plain strobed port was decided locally.
`timescale 1ns/100ps
`include "rcpc_defines.svh"
module rcpc_regs (
    // Clock and power-on reset
    input  wire logic                 clk_in,
    input  wire logic                 rstn_in,
    // Register port
    input  wire rcpc_pkg::rcpc_addr_t reg_addr_in,
    input  wire rcpc_pkg::rcpc_byte_t reg_wdata_in,
    input  wire logic                 reg_wr_in,
    input  wire logic                 reg_rd_in,
    output rcpc_pkg::rcpc_byte_t      reg_rdata_out,
    // Reset causes
    input  wire logic                 brownout_reset_in,
    input  wire logic                 watchdog_reset_in,
    input  wire logic                 reset_instr_in,
    input  wire logic                 stack_overflow_in,
    input  wire logic                 stack_underflow_in,
    input  wire logic                 memory_violation_in,
    input  wire logic                 master_clear_pin_n_in,
    // Configuration
    input  wire rcpc_pkg::rcpc_mode_t brownout_mode_config_in,
    // Detector and interrupt
    output logic                      brownout_detect_en_out,
    output logic                      brownout_ready_out,
    output logic                      irq_out
);
    import rcpc_pkg::*;

    rcpc_evt_if bo_if ();

    rcpc_byte_t cause_low_q;
    rcpc_byte_t cause_low_d;
    rcpc_byte_t cause_high_q;
    rcpc_byte_t cause_high_d;
    rcpc_byte_t low_wr_val;
    rcpc_byte_t high_wr_val;
    rcpc_byte_t hw_low;
    rcpc_byte_t hw_high;
    rcpc_byte_t ctl_rd;
    rcpc_byte_t rd_mux;
    rcpc_byte_t rdata_q;
    rcpc_byte_t irq_sts_q;
    rcpc_byte_t irq_sts_d;
    rcpc_byte_t irq_en_q;
    rcpc_byte_t irq_en_d;
    rcpc_byte_t irq_clr;
    rcpc_byte_t irq_evt;
    logic       sw_en_q;
    logic       sw_en_d;
    logic       irq_q;
    logic       ready_prev_q;
    logic       pin_s1_q;
    logic       pin_s2_q;
    logic       pin_s3_q;
    logic       pin_fall;
    logic       wr_ctl;
    logic       wr_low;
    logic       wr_high;
    logic       wr_ien;
    logic       wr_clr;

    function automatic logic addr_hit(input rcpc_addr_t a, input rcpc_addr_t off);
        return (a == off);
    endfunction : addr_hit

    // Write decode
    assign wr_ctl  = reg_wr_in && addr_hit(reg_addr_in, `RCPC_ADDR_BROWNOUT_CTL);
    assign wr_low  = reg_wr_in && addr_hit(reg_addr_in, `RCPC_ADDR_CAUSE_LOW);
    assign wr_high = reg_wr_in && addr_hit(reg_addr_in, `RCPC_ADDR_CAUSE_HIGH);
    assign wr_ien  = reg_wr_in && addr_hit(reg_addr_in, `RCPC_ADDR_IRQ_ENABLE);
    assign wr_clr  = reg_wr_in && addr_hit(reg_addr_in, `RCPC_ADDR_IRQ_CLEAR);

    // Brown-out reset reloads the enable; other resets never reach here
    assign sw_en_d = brownout_reset_in ? 1'b1
                   : wr_ctl ? reg_wdata_in[`RCPC_SW_EN_BIT] : sw_en_q;

    // Master clear pin crosses in through two stages first
    assign pin_fall = pin_s3_q && !pin_s2_q;

    // Hardware cause events, one bit per flag position
    assign hw_low = (rcpc_byte_t'(stack_overflow_in)  << `RCPC_OVF_BIT)
                  | (rcpc_byte_t'(stack_underflow_in) << `RCPC_UNF_BIT)
                  | (rcpc_byte_t'(watchdog_reset_in)  << `RCPC_WDT_BIT)
                  | (rcpc_byte_t'(pin_fall)           << `RCPC_PIN_BIT)
                  | (rcpc_byte_t'(reset_instr_in)     << `RCPC_INSTR_BIT);
    assign hw_high = rcpc_byte_t'(memory_violation_in) << `RCPC_MEM_VIOL_BIT;

    // Writes only store masked values; no reset is requested from here
    assign low_wr_val  = wr_low ? (reg_wdata_in & `RCPC_LOW_MASK) : cause_low_q;
    assign high_wr_val = wr_high ? (reg_wdata_in & `RCPC_HIGH_MASK) : cause_high_q;

    // Event beats a same-cycle write; hardware only drives toward active
    assign cause_low_d = brownout_reset_in
        ? ((`RCPC_LOW_BO & ~(8'h01 << `RCPC_POR_BIT)) | (cause_low_q & (8'h01 << `RCPC_POR_BIT)))
        : ((low_wr_val & ~hw_low) | (`RCPC_LOW_ACT & hw_low));
    assign cause_high_d = brownout_reset_in ? `RCPC_HIGH_RST
                                            : (high_wr_val & ~hw_high);

    // Interrupt status: sticky, set wins over clear
    assign irq_evt = {bo_if.ready && !ready_prev_q, memory_violation_in, brownout_reset_in,
                      watchdog_reset_in, pin_fall, reset_instr_in, stack_underflow_in,
                      stack_overflow_in};
    assign irq_clr  = wr_clr ? reg_wdata_in : 8'h00;
    assign irq_en_d = wr_ien ? reg_wdata_in : irq_en_q;
    for (genvar i = 0; i < 8; i++) begin : g_irq
        assign irq_sts_d[i] = irq_evt[i] || (irq_sts_q[i] && !irq_clr[i]);
    end

    // Read path
    assign ctl_rd = (rcpc_byte_t'(sw_en_q) << `RCPC_SW_EN_BIT)
                  | (rcpc_byte_t'(bo_if.ready) << `RCPC_READY_BIT);
    assign rd_mux = addr_hit(reg_addr_in, `RCPC_ADDR_BROWNOUT_CTL) ? ctl_rd
                  : addr_hit(reg_addr_in, `RCPC_ADDR_CAUSE_LOW)    ? cause_low_q
                  : addr_hit(reg_addr_in, `RCPC_ADDR_CAUSE_HIGH)   ? cause_high_q
                  : addr_hit(reg_addr_in, `RCPC_ADDR_IRQ_STATUS)   ? irq_sts_q
                  : addr_hit(reg_addr_in, `RCPC_ADDR_IRQ_ENABLE)   ? irq_en_q
                  : 8'h00;

    assign bo_if.sw_en = sw_en_q;
    assign bo_if.mode  = brownout_mode_config_in;

    rcpc_bo_ready u_bo_ready (
        .clk_in  (clk_in),
        .rstn_in (rstn_in),
        .bo_if   (bo_if)
    );

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
            pin_s3_q <= 1'b1;
        end else begin
            pin_s1_q <= master_clear_pin_n_in;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    // Power-on reset: brown-out flag chosen as 1, power-on flag low
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sw_en_q      <= 1'b1;
            cause_low_q  <= `RCPC_LOW_POR;
            cause_high_q <= `RCPC_HIGH_RST;
        end else begin
            sw_en_q      <= sw_en_d;
            cause_low_q  <= cause_low_d;
            cause_high_q <= cause_high_d;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_sts_q    <= 8'h00;
            irq_en_q     <= 8'h00;
            irq_q        <= 1'b0;
            ready_prev_q <= 1'b0;
            rdata_q      <= 8'h00;
        end else begin
            irq_sts_q    <= irq_sts_d;
            irq_en_q     <= irq_en_d;
            irq_q        <= |(irq_sts_d & irq_en_d);
            ready_prev_q <= bo_if.ready;
            rdata_q      <= reg_rd_in ? rd_mux : 8'h00;
        end
    end

    assign reg_rdata_out          = rdata_q;
    assign irq_out                = irq_q;
    assign brownout_detect_en_out = bo_if.det_en;
    assign brownout_ready_out     = bo_if.ready;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    property p_rd_low;
        reg_rd_in && reg_addr_in == `RCPC_ADDR_CAUSE_LOW |=> reg_rdata_out == $past(cause_low_q);
    endproperty
    a_rd_low: assert property (p_rd_low) else $error("cause low read mismatch");

    property p_sw_en_reload;
        brownout_reset_in |=> sw_en_q;
    endproperty
    a_sw_en_reload: assert property (p_sw_en_reload) else $error("software enable not reloaded");

    property p_sw_en_mode;
        brownout_mode_config_in == `RCPC_MODE_SW |=> brownout_detect_en_out == $past(sw_en_q);
    endproperty
    a_sw_en_mode: assert property (p_sw_en_mode) else $error("software enable not followed");

    property p_mode_ignore;
        $stable(brownout_mode_config_in) && brownout_mode_config_in != `RCPC_MODE_SW
            |=> $stable(brownout_detect_en_out);
    endproperty
    a_mode_ignore: assert property (p_mode_ignore) else $error("enable leaked outside mode 01");

    property p_ready_en;
        brownout_ready_out |-> $past(brownout_detect_en_out);
    endproperty
    a_ready_en: assert property (p_ready_en) else $error("ready while detector off");

    property p_ovf;
        stack_overflow_in && !brownout_reset_in |=> cause_low_q[`RCPC_OVF_BIT];
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag not set");

    property p_unf;
        stack_underflow_in && !brownout_reset_in |=> cause_low_q[`RCPC_UNF_BIT];
    endproperty
    a_unf: assert property (p_unf) else $error("underflow flag not set");

    property p_wdt;
        watchdog_reset_in && !brownout_reset_in |=> !cause_low_q[`RCPC_WDT_BIT];
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog flag not driven low");

    property p_pin;
        $fell(master_clear_pin_n_in) ##1 !master_clear_pin_n_in [*2] ##0 !brownout_reset_in
            |=> !cause_low_q[`RCPC_PIN_BIT];
    endproperty
    a_pin: assert property (p_pin) else $error("pin reset flag not driven low");

    property p_instr;
        reset_instr_in && !brownout_reset_in |=> !cause_low_q[`RCPC_INSTR_BIT];
    endproperty
    a_instr: assert property (p_instr) else $error("instruction flag not driven low");

    property p_por_kept;
        !wr_low |=> $stable(cause_low_q[`RCPC_POR_BIT]);
    endproperty
    a_por_kept: assert property (p_por_kept) else $error("power-on flag moved without write");

    property p_bo_load;
        brownout_reset_in |=> !cause_low_q[`RCPC_BO_BIT] && cause_low_q[`RCPC_WDT_BIT];
    endproperty
    a_bo_load: assert property (p_bo_load) else $error("brown-out values not loaded");

    property p_mem_viol;
        memory_violation_in && !brownout_reset_in |=> !cause_high_q[`RCPC_MEM_VIOL_BIT];
    endproperty
    a_mem_viol: assert property (p_mem_viol) else $error("memory violation flag not low");

    property p_mem_viol_rise;
        $rose(cause_high_q[`RCPC_MEM_VIOL_BIT]) |-> $past(wr_high || brownout_reset_in);
    endproperty
    a_mem_viol_rise: assert property (p_mem_viol_rise) else $error("memory flag rose on its own");

    property p_high_wr;
        wr_high && !brownout_reset_in && !memory_violation_in
            |=> cause_high_q[`RCPC_MEM_VIOL_BIT] == $past(reg_wdata_in[`RCPC_MEM_VIOL_BIT]);
    endproperty
    a_high_wr: assert property (p_high_wr) else $error("memory flag write lost");

    property p_ctl_rd;
        reg_rd_in && reg_addr_in == `RCPC_ADDR_BROWNOUT_CTL
            |=> reg_rdata_out[0] == $past(brownout_ready_out) && reg_rdata_out[6:1] == 6'h00;
    endproperty
    a_ctl_rd: assert property (p_ctl_rd) else $error("control read mismatch");

    property p_no_self_clear;
        $rose(cause_low_q[`RCPC_WDT_BIT]) |-> $past(wr_low || brownout_reset_in);
    endproperty
    a_no_self_clear: assert property (p_no_self_clear) else $error("hardware deasserted a flag");

    property p_reserved;
        reg_rd_in && reg_addr_in == `RCPC_ADDR_RESERVED |=> reg_rdata_out == 8'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved read not zero");

    property p_unimpl;
        cause_low_q[5] == 1'b0 && cause_high_q[7:2] == 6'h00 && cause_high_q[0] == 1'b0;
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set");

    property p_c_ready;
        $rose(brownout_ready_out);
    endproperty
    c_ready: cover property (p_c_ready);

    property p_c_irq;
        watchdog_reset_in ##1 irq_out;
    endproperty
    c_irq: cover property (p_c_irq);

    property p_c_set_clr;
        wr_low && watchdog_reset_in;
    endproperty
    c_set_clr: cover property (p_c_set_clr);

    property p_c_bo_load;
        brownout_reset_in ##1 cause_low_q[`RCPC_POR_BIT];
    endproperty
    c_bo_load: cover property (p_c_bo_load);
endmodule : rcpc_regs

//--- rtl/rcpc_defines.svh
`ifndef RCPC_DEFINES_SVH
`define RCPC_DEFINES_SVH

// Register map
`define RCPC_ADDR_BROWNOUT_CTL 12'h811
`define RCPC_ADDR_RESERVED     12'h812
`define RCPC_ADDR_CAUSE_LOW    12'h813
`define RCPC_ADDR_CAUSE_HIGH   12'h814
`define RCPC_ADDR_IRQ_STATUS   12'h818
`define RCPC_ADDR_IRQ_ENABLE   12'h819
`define RCPC_ADDR_IRQ_CLEAR    12'h81a

// Brown-out control fields
`define RCPC_SW_EN_BIT   7
`define RCPC_READY_BIT   0
`define RCPC_MODE_SW     2'h1
`define RCPC_MODE_ON_BIT 1

// Reset-cause low fields
`define RCPC_OVF_BIT   7
`define RCPC_UNF_BIT   6
`define RCPC_WDT_BIT   4
`define RCPC_PIN_BIT   3
`define RCPC_INSTR_BIT 2
`define RCPC_POR_BIT   1
`define RCPC_BO_BIT    0
`define RCPC_LOW_MASK  8'hdf
`define RCPC_LOW_ACT   8'hc0
`define RCPC_LOW_POR   8'h1d
`define RCPC_LOW_BO    8'h1c

// Reset-cause high fields
`define RCPC_MEM_VIOL_BIT 1
`define RCPC_HIGH_MASK  8'h02
`define RCPC_HIGH_RST   8'h02

// Timing
`define RCPC_CLK_MHZ   20
`define RCPC_WARMUP_NS 2000
`define RCPC_WARM_CYC  ((`RCPC_WARMUP_NS * `RCPC_CLK_MHZ + 999) / 1000)
`define RCPC_WARM_W    8

`endif

//--- rtl/rcpc_pkg.sv
package rcpc_pkg;
    typedef logic [7:0]  rcpc_byte_t;
    typedef logic [11:0] rcpc_addr_t;
    typedef logic [1:0]  rcpc_mode_t;
    typedef enum logic [1:0] {BO_OFF, BO_WARM, BO_ARMED} rcpc_bo_state_t;
endpackage : rcpc_pkg

//--- rtl/rcpc_evt_if.sv
`timescale 1ns/100ps
interface rcpc_evt_if;
    logic       sw_en;
    logic [1:0] mode;
    logic       det_en;
    logic       ready;
    modport core (output sw_en, output mode, input det_en, input ready);
    modport det  (input sw_en, input mode, output det_en, output ready);
endinterface : rcpc_evt_if

//--- rtl/rcpc_bor_ready.sv
`timescale 1ns/100ps
`include "rcpc_defines.svh"
module rcpc_bo_ready (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Detector control
    rcpc_evt_if.det  bo_if
);
    import rcpc_pkg::*;

    localparam int warm_last_c = `RCPC_WARM_CYC - 1;

    logic                    det_en_d;
    logic                    det_en_q;
    logic                    ready_q;
    logic                    warm_done;
    logic [`RCPC_WARM_W-1:0] warm_last;
    rcpc_bo_state_t          state_q;
    rcpc_bo_state_t          state_d;
    logic [`RCPC_WARM_W-1:0] cnt_q;
    logic [`RCPC_WARM_W-1:0] cnt_d;

    // Software enable only counts in software mode
    assign det_en_d  = (bo_if.mode == `RCPC_MODE_SW) ? bo_if.sw_en
                                                     : bo_if.mode[`RCPC_MODE_ON_BIT];
    assign warm_last = warm_last_c[`RCPC_WARM_W-1:0];
    assign warm_done = (cnt_q == warm_last);

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        unique case (state_q)
            BO_OFF: begin
                if (det_en_q) begin
                    state_d = BO_WARM;
                    cnt_d   = '0;
                end
            end
            BO_WARM: begin
                if (!det_en_q) begin
                    state_d = BO_OFF;
                end else if (warm_done) begin
                    state_d = BO_ARMED;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            BO_ARMED: begin
                if (!det_en_q) begin
                    state_d = BO_OFF;
                end
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_q  <= BO_OFF;
            cnt_q    <= '0;
            det_en_q <= 1'b0;
            ready_q  <= 1'b0;
        end else begin
            state_q  <= state_d;
            cnt_q    <= cnt_d;
            det_en_q <= det_en_d;
            ready_q  <= (state_d == BO_ARMED);
        end
    end

    assign bo_if.det_en = det_en_q;
    assign bo_if.ready  = ready_q;
endmodule : rcpc_bo_ready

//--- tb/rcpc_tb.sv
`timescale 1ns/100ps
module tb;
    import rcpc_pkg::*;

    logic       clk_in;
    logic       rstn_in;
    rcpc_addr_t addr;
    rcpc_byte_t wdata;
    logic       wr;
    logic       rd;
    rcpc_byte_t rdata;
    logic [5:0] ev;
    logic       pin_n;
    rcpc_mode_t mode;
    logic       det_en;
    logic       ready;
    logic       irq;
    int         fail_count;
    int         compares;

    rcpc_regs rcpc_regs_i (
        .clk_in                  (clk_in),
        .rstn_in                 (rstn_in),
        .reg_addr_in             (addr),
        .reg_wdata_in            (wdata),
        .reg_wr_in               (wr),
        .reg_rd_in               (rd),
        .reg_rdata_out           (rdata),
        .brownout_reset_in       (ev[0]),
        .watchdog_reset_in       (ev[1]),
        .reset_instr_in          (ev[2]),
        .stack_overflow_in       (ev[3]),
        .stack_underflow_in      (ev[4]),
        .memory_violation_in     (ev[5]),
        .master_clear_pin_n_in   (pin_n),
        .brownout_mode_config_in (mode),
        .brownout_detect_en_out  (det_en),
        .brownout_ready_out      (ready),
        .irq_out                 (irq)
    );

    always #25 clk_in = ~clk_in;

    task automatic chk(input rcpc_byte_t got, input rcpc_byte_t exp, input string what);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr_reg(input rcpc_addr_t a, input rcpc_byte_t d);
        @(posedge clk_in);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_in);
        wr    <= 1'b0;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe, so look mid-cycle
    task automatic rd_chk(input rcpc_addr_t a, input rcpc_byte_t exp);
        @(posedge clk_in);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_in);
        rd   <= 1'b0;
        @(negedge clk_in);
        chk(rdata, exp, $sformatf("read %h", a));
    endtask : rd_chk

    task automatic pulse(input int k);
        @(posedge clk_in);
        ev[k] <= 1'b1;
        @(posedge clk_in);
        ev    <= '0;
    endtask : pulse

    task automatic settle();
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
    endtask : settle

    task automatic check_reset_values();
        rd_chk(12'h811, 8'h80);
        rd_chk(12'h812, 8'h00);
        rd_chk(12'h813, 8'h1d);
        rd_chk(12'h814, 8'h02);
        rd_chk(12'h818, 8'h00);
        rd_chk(12'h819, 8'h00);
        rd_chk(12'h81a, 8'h00);
        rd_chk(12'h900, 8'h00);
        settle();
        chk({7'h0, irq}, 8'h00, "irq after reset");
    endtask : check_reset_values

    task automatic wrap_up();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up

    initial begin
        // Far beyond the few hundred cycles the tests need
        #(50 * 5000);
        fail_count++;
        wrap_up();
    end

    initial begin
        clk_in     = 1'b0;
        rstn_in    = 1'b0;
        addr       = '0;
        wdata      = '0;
        wr         = 1'b0;
        rd         = 1'b0;
        ev         = '0;
        pin_n      = 1'b1;
        mode       = 2'h0;
        fail_count = 0;
        compares   = 0;
        repeat (6) @(posedge clk_in);
        rstn_in <= 1'b1;
        check_reset_values();
        $display("test reset values done");

        wr_reg(12'h811, 8'hff);
        rd_chk(12'h811, 8'h80);
        wr_reg(12'h812, 8'hff);
        rd_chk(12'h812, 8'h00);
        wr_reg(12'h811, 8'h00);
        rd_chk(12'h811, 8'h00);
        wr_reg(12'h811, 8'h80);
        $display("test control access done");

        wr_reg(12'h819, 8'hff);
        pulse(1);
        settle();
        chk({7'h0, irq}, 8'h01, "irq on watchdog");
        rd_chk(12'h813, 8'h0d);
        pulse(2);
        rd_chk(12'h813, 8'h09);
        pulse(3);
        rd_chk(12'h813, 8'h89);
        pulse(4);
        rd_chk(12'h813, 8'hc9);
        @(posedge clk_in);
        pin_n <= 1'b0;
        repeat (5) @(posedge clk_in);
        pin_n <= 1'b1;
        rd_chk(12'h813, 8'hc1);
        pulse(5);
        rd_chk(12'h814, 8'h00);
        rd_chk(12'h818, 8'h5f);
        $display("test reset causes done");

        wr_reg(12'h819, 8'h00);
        settle();
        chk({7'h0, irq}, 8'h00, "irq masked");
        wr_reg(12'h819, 8'h40);
        settle();
        chk({7'h0, irq}, 8'h01, "irq enabled");
        wr_reg(12'h81a, 8'hff);
        settle();
        chk({7'h0, irq}, 8'h00, "irq cleared");
        rd_chk(12'h818, 8'h00);
        rd_chk(12'h81a, 8'h00);
        $display("test interrupt done");

        wr_reg(12'h813, 8'hff);
        rd_chk(12'h813, 8'hdf);
        wr_reg(12'h814, 8'hff);
        rd_chk(12'h814, 8'h02);
        wr_reg(12'h813, 8'h00);
        rd_chk(12'h813, 8'h00);
        rd_chk(12'h814, 8'h02);
        rd_chk(12'h811, 8'h80);
        $display("test firmware writes done");

        // Brown-out keeps only the power-on bit of the old contents
        wr_reg(12'h813, 8'hde);
        wr_reg(12'h814, 8'h00);
        wr_reg(12'h811, 8'h00);
        pulse(0);
        rd_chk(12'h813, 8'h1e);
        rd_chk(12'h814, 8'h02);
        rd_chk(12'h811, 8'h80);
        $display("test brown-out reset done");

        wr_reg(12'h811, 8'h00);
        @(posedge clk_in);
        mode <= 2'h1;
        settle();
        chk({7'h0, det_en}, 8'h00, "detector off by software");
        wr_reg(12'h811, 8'h80);
        settle();
        chk({7'h0, det_en}, 8'h01, "detector on by software");
        repeat (30) @(posedge clk_in);
        @(negedge clk_in);
        chk({7'h0, ready}, 8'h00, "ready during warm-up");
        for (int i = 0; i < 20 && ready !== 1'b1; i++) @(posedge clk_in);
        @(negedge clk_in);
        chk({7'h0, ready}, 8'h01, "ready after warm-up");
        rd_chk(12'h811, 8'h81);
        @(posedge clk_in);
        mode <= 2'h0;
        settle();
        chk({7'h0, det_en}, 8'h00, "mode off ignores enable");
        chk({7'h0, ready}, 8'h00, "ready drops");
        wr_reg(12'h811, 8'h00);
        @(posedge clk_in);
        mode <= 2'h2;
        settle();
        chk({7'h0, det_en}, 8'h01, "mode on ignores enable");
        rd_chk(12'h811, 8'h00);
        $display("test detector done");

        @(posedge clk_in);
        mode    <= 2'h0;
        rstn_in <= 1'b0;
        repeat (6) @(posedge clk_in);
        rstn_in <= 1'b1;
        check_reset_values();
        $display("test second reset done");
        wrap_up();
    end
endmodule : tb
